// ===== ihb_host_port.sv
`timescale 1ns/1ps
// Behaviour
// RULE1 - Strobes ignored unless chip select low
// RULE2 - Direction high means read, low write
// RULE3 - Write strobe low captures write data
// RULE4 - Data strobe rise ends access
// RULE5 - Read strobe low drives register data
// RULE6 - Interrupt pin sinks low while pending
// RULE7 - Latch enable high latches multiplexed address
// RULE8 - Latch enable activity selects multiplexed mode
// RULE9 - Multiplexed lines carry address then data
// RULE10 - Non-multiplexed address from six pins
// RULE11 - Reset pin high resets the device
// RULE12 - Terminal mode may drive reset out
// RULE13 - Wake falling edge: interrupt and reset
// RULE14 - Synchronise strobes and wake before use
module ihb_host_port
	import ihb_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	// Configuration
	input  wire logic                  bus_style_strobe_dir,
	input  wire logic                  term_func_en,
	// Host control pins
	input  wire logic                  host_select_n,
	input  wire logic                  write_n_or_direction,
	input  wire logic                  read_n_or_strobe,
	input  wire logic                  addr_latch_strobe,
	// Host address and data pins
	input  wire logic [PIN_ADDR_W-1:0] host_addr_bit,
	input  wire logic                  addr5_or_wake,
	input  wire logic [DATA_W-1:0]     shared_bus_line_in,
	output logic      [DATA_W-1:0]     shared_bus_line_out,
	output logic                       shared_bus_line_oe,
	// Interrupt pin, open drain
	output logic                       irq_out_n_out,
	output logic                       irq_out_n_oe,
	// Reset pin, two way
	input  wire logic                  reset_pin_bidir_in,
	output logic                       reset_pin_bidir_out,
	output logic                       reset_pin_bidir_oe,
	// Internal register side
	output logic      [ADDR_W-1:0]     reg_addr,
	output logic      [DATA_W-1:0]     reg_wr_data,
	output logic                       reg_wr,
	output logic                       reg_rd,
	input  wire logic [DATA_W-1:0]     reg_rd_data,
	// Core side status and events
	input  wire logic                  core_irq_req,
	input  wire logic                  wake_irq_clear,
	output logic                       wake_irq_pending,
	output logic                       mux_mode,
	output logic                       dev_reset
);

	// ==========================================================
	// Helpers
	function automatic logic fell(input logic prev, input logic cur);
		fell = prev & ~cur;
	endfunction

	function automatic logic rose(input logic prev, input logic cur);
		rose = ~prev & cur;
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic                  cs_n_m_r, cs_n_r;
	logic                  wrd_m_r, wrd_r;
	logic                  rds_m_r, rds_r;
	logic                  ale_m_r, ale_r;
	logic                  wake_m_r, wake_r;
	logic                  rpin_m_r, rpin_r;
	logic [PIN_ADDR_W-1:0] addr_m_r, addr_r;
	logic [DATA_W-1:0]     data_m_r, data_r;
	logic                  wrd_d_r, rds_d_r, wake_d_r;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cs_n_m_r <= 1'b1;
			cs_n_r   <= 1'b1;
			wrd_m_r  <= 1'b1;
			wrd_r    <= 1'b1;
			rds_m_r  <= 1'b1;
			rds_r    <= 1'b1;
			ale_m_r  <= 1'b0;
			ale_r    <= 1'b0;
			wake_m_r <= 1'b1;
			wake_r   <= 1'b1;
			rpin_m_r <= 1'b0;
			rpin_r   <= 1'b0;
			addr_m_r <= 5'h00;
			addr_r   <= 5'h00;
			data_m_r <= BUS_RST;
			data_r   <= BUS_RST;
			wrd_d_r  <= 1'b1;
			rds_d_r  <= 1'b1;
			wake_d_r <= 1'b1;
		end else begin
			cs_n_m_r <= host_select_n; // RULE14
			cs_n_r   <= cs_n_m_r;
			wrd_m_r  <= write_n_or_direction;
			wrd_r    <= wrd_m_r;
			rds_m_r  <= read_n_or_strobe;
			rds_r    <= rds_m_r;
			ale_m_r  <= addr_latch_strobe;
			ale_r    <= ale_m_r;
			wake_m_r <= addr5_or_wake; // RULE14
			wake_r   <= wake_m_r;
			rpin_m_r <= reset_pin_bidir_in;
			rpin_r   <= rpin_m_r;
			addr_m_r <= host_addr_bit;
			addr_r   <= addr_m_r;
			data_m_r <= shared_bus_line_in;
			data_r   <= data_m_r;
			// One cycle history for edge detection on synchronised levels
			wrd_d_r  <= wrd_r;
			rds_d_r  <= rds_r;
			wake_d_r <= wake_r;
		end
	end

	// ==========================================================
	// Local reset: system reset or reset pin held high
	logic blk_rst;
	assign blk_rst = !reset_n || rpin_r; // RULE11

	// ==========================================================
	// Bus type and address path
	logic             mux_mode_r;
	logic [ADDR_W-1:0] mux_addr_r;

	// Once latch enable has been seen high the port stays multiplexed;
	// a tied-low latch enable leaves it in separate-address form.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mux_mode_r <= 1'b0;
		end else if (ale_r) begin
			mux_mode_r <= 1'b1; // RULE8
		end
	end

	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			mux_addr_r <= ADDR_RST;
		end else if (ale_r) begin
			mux_addr_r <= data_r[ADDR_W-1:0]; // RULE7 RULE9
		end
	end

	// In terminal mode the top address pin is the wake line, not address
	logic [ADDR_W-1:0] cur_addr;
	assign cur_addr = mux_mode_r ? mux_addr_r
		: {(term_func_en ? 1'b0 : wake_r), addr_r}; // RULE10 RULE13

	// ==========================================================
	// Access decode per bus style
	logic sel;
	logic acc_start_rd, acc_start_wr, acc_end;
	assign sel = ~cs_n_r; // RULE1

	always_comb begin
		acc_start_rd = 1'b0;
		acc_start_wr = 1'b0;
		acc_end      = 1'b0;
		if (bus_style_strobe_dir) begin
			// Direction sampled when the data strobe falls
			acc_start_rd = sel && fell(rds_d_r, rds_r) && wrd_r;  // RULE2
			acc_start_wr = sel && fell(rds_d_r, rds_r) && !wrd_r; // RULE2
			acc_end      = rose(rds_d_r, rds_r) || cs_n_r;        // RULE4
		end else begin
			acc_start_rd = sel && fell(rds_d_r, rds_r) && wrd_r;  // RULE5
			acc_start_wr = sel && fell(wrd_d_r, wrd_r) && rds_r;  // RULE3
			acc_end      = (rds_r && wrd_r) || cs_n_r;
		end
	end

	// ==========================================================
	// Access sequencer
	ihb_acc_type       acc_r, acc_nxt;
	logic [ADDR_W-1:0] reg_addr_r;
	logic [DATA_W-1:0] reg_wr_data_r;
	logic              reg_wr_r, reg_rd_r;
	logic [DATA_W-1:0] bus_out_r;
	logic              bus_oe_r;

	always_comb begin
		acc_nxt = acc_r;
		case (acc_r)
			IHB_IDLE: begin
				if (acc_start_rd) begin
					acc_nxt = IHB_RD_FETCH;
				end else if (acc_start_wr) begin
					acc_nxt = IHB_WR_HOLD;
				end
			end
			IHB_RD_FETCH: begin
				acc_nxt = acc_end ? IHB_IDLE : IHB_RD_DRIVE;
			end
			IHB_RD_DRIVE: begin
				if (acc_end) begin
					acc_nxt = IHB_IDLE;
				end
			end
			IHB_WR_HOLD: begin
				if (acc_end) begin
					acc_nxt = IHB_IDLE;
				end
			end
			default: begin
				acc_nxt = IHB_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			acc_r <= IHB_IDLE;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// Address is frozen at the start of each access
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			reg_addr_r <= ADDR_RST;
		end else if (acc_r == IHB_IDLE && (acc_start_rd || acc_start_wr)) begin
			reg_addr_r <= cur_addr;
		end
	end

	// Write data follows the bus for the whole low phase, committed at the end
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			reg_wr_data_r <= BUS_RST;
			reg_wr_r      <= 1'b0;
		end else begin
			reg_wr_r <= 1'b0;
			if ((acc_r == IHB_IDLE && acc_start_wr) || acc_r == IHB_WR_HOLD) begin
				reg_wr_data_r <= data_r; // RULE3
			end
			if (acc_r == IHB_WR_HOLD && acc_end) begin
				reg_wr_r <= 1'b1; // RULE4
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			reg_rd_r <= 1'b0;
		end else begin
			reg_rd_r <= (acc_r == IHB_IDLE) && acc_start_rd;
		end
	end

	// Read data is driven only while the strobe stays active
	always_ff @(posedge sys_clk) begin
		if (blk_rst) begin
			bus_out_r <= BUS_RST;
			bus_oe_r  <= 1'b0;
		end else begin
			if (acc_r == IHB_RD_FETCH) begin
				bus_out_r <= reg_rd_data;
			end
			bus_oe_r <= (acc_r == IHB_RD_FETCH || acc_r == IHB_RD_DRIVE)
				&& !acc_end; // RULE5 RULE4 RULE1
		end
	end

	// ==========================================================
	// Wake line and reset pulse
	logic                 wake_evt;
	logic                 wake_pend_r;
	logic [RST_CNT_W-1:0] rst_cnt_r;
	logic                 rst_drv_r;

	assign wake_evt = term_func_en && fell(wake_d_r, wake_r); // RULE13

	// A wake event in the same cycle as the clear keeps the flag set
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wake_pend_r <= 1'b0;
		end else if (wake_evt) begin
			wake_pend_r <= 1'b1; // RULE13
		end else if (wake_irq_clear) begin
			wake_pend_r <= 1'b0;
		end
	end

	// Own pulse is not cleared by the pin read-back, else it would cut itself short
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rst_cnt_r <= RST_CNT_RST;
			rst_drv_r <= 1'b0;
		end else if (wake_evt && term_func_en) begin
			rst_cnt_r <= RST_CNT_LOAD;
			rst_drv_r <= 1'b1; // RULE12
		end else if (rst_cnt_r != RST_CNT_RST) begin
			rst_cnt_r <= rst_cnt_r - 1'b1;
			rst_drv_r <= (rst_cnt_r != RST_CNT_W'(1));
		end else begin
			rst_drv_r <= 1'b0;
		end
	end

	// ==========================================================
	// Output registers
	logic irq_oe_r;
	logic dev_reset_r;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			irq_oe_r <= 1'b0;
		end else begin
			irq_oe_r <= core_irq_req || wake_pend_r; // RULE6
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			dev_reset_r <= 1'b1;
		end else begin
			dev_reset_r <= rpin_r || rst_drv_r; // RULE11
		end
	end

	// Open drain: the pin level is always low, only the enable moves
	assign irq_out_n_out       = 1'b0;
	assign irq_out_n_oe        = irq_oe_r;
	assign reset_pin_bidir_out = rst_drv_r;
	assign reset_pin_bidir_oe  = rst_drv_r;
	assign shared_bus_line_out = bus_out_r;
	assign shared_bus_line_oe  = bus_oe_r;
	assign reg_addr            = reg_addr_r;
	assign reg_wr_data         = reg_wr_data_r;
	assign reg_wr              = reg_wr_r;
	assign reg_rd              = reg_rd_r;
	assign wake_irq_pending    = wake_pend_r;
	assign mux_mode            = mux_mode_r;
	assign dev_reset           = dev_reset_r;

endmodule

// ===== ihb_pkg.sv
package ihb_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 6;
	localparam int PIN_ADDR_W = 5;

	// ==========================================================
	// Timing
	localparam int SYS_CLK_KHZ = 10000;
	localparam int DCL_FREQ_KHZ = 1536;
	localparam int RST_PULSE_DCL = 4;
	// Least time, so round up to whole system clocks
	localparam int RST_PULSE_CYC =
		(RST_PULSE_DCL * SYS_CLK_KHZ + DCL_FREQ_KHZ - 1) / DCL_FREQ_KHZ;
	localparam int RST_CNT_W = 6;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] BUS_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
	localparam logic [RST_CNT_W-1:0] RST_CNT_RST = 6'h00;
	localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = RST_CNT_W'(RST_PULSE_CYC);

	// ==========================================================
	// Access sequencer
	typedef enum logic [1:0] {
		IHB_IDLE,
		IHB_RD_FETCH,
		IHB_RD_DRIVE,
		IHB_WR_HOLD
	} ihb_acc_type;

endpackage

// ===== ihb_host_port_checker.sv
`timescale 1ns/1ps
module ihb_host_port_checker
	import ihb_pkg::*;
(
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              reset_n,
	// Host pins
	input wire logic              term_func_en,
	input wire logic              host_select_n,
	input wire logic              read_n_or_strobe,
	input wire logic              addr_latch_strobe,
	input wire logic              addr5_or_wake,
	input wire logic [DATA_W-1:0] shared_bus_line_out,
	input wire logic              shared_bus_line_oe,
	input wire logic              irq_out_n_out,
	input wire logic              irq_out_n_oe,
	input wire logic              reset_pin_bidir_in,
	input wire logic              reset_pin_bidir_out,
	input wire logic              reset_pin_bidir_oe,
	// Core side
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rd_data,
	input wire logic              core_irq_req,
	input wire logic              wake_irq_pending,
	input wire logic              mux_mode,
	input wire logic              dev_reset
);
	// ==========================================================
	// Helpers
	logic [RST_CNT_W-1:0] pulse_r;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge sys_clk) begin
		pulse_r <= reset_pin_bidir_oe ? pulse_r + 6'h01 : RST_CNT_RST;
	end
	// Host still holds the strobe when read data is due
	sequence s_rd_held;
		reg_rd ##1 !read_n_or_strobe;
	endsequence
	// ==========================================================
	// Assertions
	a_sel_quiet: assert property (host_select_n [*6] |-> !reg_wr && !reg_rd)
		else $error("access taken while deselected");
	a_rd_data: assert property (s_rd_held |-> shared_bus_line_oe &&
		shared_bus_line_out == $past(reg_rd_data)) else $error("read data not driven");
	a_rd_once: assert property (reg_rd |=> !reg_rd [*2])
		else $error("read taken twice");
	a_wr_quiet: assert property (reg_wr |-> !shared_bus_line_oe)
		else $error("bus driven during write");
	a_oe_release: assert property ($rose(read_n_or_strobe) && shared_bus_line_oe
		|-> ##[1:5] !shared_bus_line_oe) else $error("bus not released");
	a_irq_drive: assert property (core_irq_req [*4] |-> ##[0:3]
		(irq_out_n_oe && irq_out_n_out == 1'h0)) else $error("interrupt not driven");
	a_irq_quiet: assert property ((!core_irq_req && !wake_irq_pending) [*4] |-> !irq_out_n_oe)
		else $error("interrupt driven while idle");
	a_pin_reset: assert property (reset_pin_bidir_in [*3] |=> dev_reset)
		else $error("reset pin ignored");
	a_wake_set: assert property (term_func_en && $fell(addr5_or_wake) |-> ##[1:4] wake_irq_pending)
		else $error("wake edge missed");
	a_pulse_len: assert property ($fell(reset_pin_bidir_oe) |-> pulse_r == RST_CNT_LOAD)
		else $error("reset pulse length");
	a_own_reset: assert property (reset_pin_bidir_oe |-> reset_pin_bidir_out ##1 dev_reset)
		else $error("reset pulse not driven");
	a_mux_seen: assert property (addr_latch_strobe [*3] |-> ##[0:2] mux_mode)
		else $error("multiplexed form not taken");
endmodule

bind ihb_host_port ihb_host_port_checker chk_u (.*);

// ===== ihb_host_model.sv
`timescale 1ns/1ps
module ihb_host_model
	import ihb_pkg::*;
(
	// Clock and bus style
	input wire logic                  sys_clk,
	input wire logic                  ds_mode,
	input wire logic                  mux,
	// Data pins seen and device enable
	input wire logic [DATA_W-1:0]     bus,
	input wire logic                  bus_oe,
	// Pins driven
	output logic                      sel_n,
	output logic                      wr_dir,
	output logic                      rd_ds,
	output logic                      ale,
	output logic [PIN_ADDR_W-1:0]     addr,
	output logic                      a5,
	output logic [DATA_W-1:0]         dat,
	output logic                      dat_oe
);
	initial begin
		{sel_n, wr_dir, rd_ds, ale, a5, dat_oe} = 6'h3a;
		addr = 5'h00;
		dat = 8'h00;
	end
	// Address bit 5 doubles as the wake line in terminal mode
	task automatic wake_line(input logic v);
		a5 <= v;
	endtask
	// ==========================================================
	// One access; address pins carry junk in mux form to prove the bus is used
	task automatic acc(input logic rd, input logic sel, input logic [ADDR_W-1:0] a,
		inout logic [DATA_W-1:0] d, output logic got);
		got = '0;
		@(posedge sys_clk);
		sel_n <= sel;
		addr <= mux ? ~a[4:0] : a[4:0];
		a5 <= mux ? '1 : a[5];
		dat <= mux ? {2'h0, a} : d;
		dat_oe <= mux || !rd;
		ale <= mux;
		wr_dir <= ds_mode ? rd : '1;
		repeat (3) @(posedge sys_clk);
		ale <= '0;
		repeat (3) @(posedge sys_clk);
		dat <= d;
		dat_oe <= !rd;
		@(posedge sys_clk);
		if (ds_mode || rd) rd_ds <= '0;
		else wr_dir <= '0;
		for (int n = 0; n < 12 && !got; n++) begin
			@(posedge sys_clk);
			got = bus_oe;
		end
		if (got) d = bus;
		rd_ds <= '1;
		if (!ds_mode) wr_dir <= '1;
		repeat (4) @(posedge sys_clk);
		sel_n <= '1;
		wr_dir <= '1;
		dat_oe <= '0;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule

// ===== ihb_host_port_test.sv
`timescale 1ns/1ps
module ihb_host_port_test
	import ihb_pkg::*;
;
	logic sys_clk = '0, reset_n = '0, ds_mode = '0, term_func_en = '0, mux = '0;
	logic rst_in = '0, core_irq = '0, wclr = '0, got;
	logic sel_n, wr_dir, rd_ds, ale, a5, h_oe, oe, irq_out, irq_oe;
	logic rst_out, rst_oe, reg_wr, reg_rd, pend, mux_mode, dev_reset;
	logic [PIN_ADDR_W-1:0] addr;
	logic [DATA_W-1:0] h_dat, out, bus, wdata, d, rd_data;
	logic [ADDR_W-1:0] raddr;
	logic [DATA_W-1:0] mem [64];
	int fail_count = 0, n_checks = 0, cyc = 0, n;
	// Undriven bus shows the inverse so stale data never passes
	assign bus = oe ? out : (h_oe ? h_dat : ~h_dat);
	always #50 sys_clk = ~sys_clk;

	ihb_host_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .bus_style_strobe_dir(ds_mode),
		.term_func_en(term_func_en), .host_select_n(sel_n), .write_n_or_direction(wr_dir),
		.read_n_or_strobe(rd_ds), .addr_latch_strobe(ale), .host_addr_bit(addr),
		.addr5_or_wake(a5), .shared_bus_line_in(bus), .shared_bus_line_out(out),
		.shared_bus_line_oe(oe), .irq_out_n_out(irq_out), .irq_out_n_oe(irq_oe),
		.reset_pin_bidir_in(rst_in), .reset_pin_bidir_out(rst_out), .reset_pin_bidir_oe(rst_oe),
		.reg_addr(raddr), .reg_wr_data(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rd_data(rd_data), .core_irq_req(core_irq), .wake_irq_clear(wclr),
		.wake_irq_pending(pend), .mux_mode(mux_mode), .dev_reset(dev_reset));
	ihb_host_model host_u (.sys_clk(sys_clk), .ds_mode(ds_mode), .mux(mux), .bus(bus),
		.bus_oe(oe), .sel_n(sel_n), .wr_dir(wr_dir), .rd_ds(rd_ds), .ale(ale), .addr(addr),
		.a5(a5), .dat(h_dat), .dat_oe(h_oe));

	// ==========================================================
	// Core register file; the port samples read data while the read pulse stands
	assign rd_data = mem[raddr];
	always @(posedge sys_clk) begin
		if (reg_wr) mem[raddr] <= wdata;
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_sep();
		d = 8'h5a;
		host_u.acc('0, '0, 6'h2b, d, got);
		chk(mem[6'h2b], 8'h5a);
		host_u.acc('1, '0, 6'h0b, d, got);
		chk(d, 8'h37);
		host_u.acc('1, '0, 6'h2b, d, got);
		chk(d, 8'h5a);
		d = 8'h11;
		host_u.acc('0, '1, 6'h2b, d, got);
		chk(mem[6'h2b], 8'h5a);
		host_u.acc('1, '1, 6'h2b, d, got);
		chk(got, 1'h0);
	endtask

	task automatic t_ds();
		ds_mode <= '1;
		d = 8'ha7;
		host_u.acc('0, '0, 6'h05, d, got);
		chk(mem[6'h05], 8'ha7);
		d = 8'h00;
		host_u.acc('1, '0, 6'h05, d, got);
		chk(d, 8'ha7);
		ds_mode <= '0;
	endtask

	task automatic t_irq_pin();
		core_irq <= '1;
		repeat (4) @(posedge sys_clk);
		chk({irq_oe, irq_out}, 8'h02);
		core_irq <= '0;
		rst_in <= '1;
		repeat (6) @(posedge sys_clk);
		chk({irq_oe, dev_reset}, 8'h01);
		rst_in <= '0;
		repeat (5) @(posedge sys_clk);
		chk(dev_reset, 1'h0);
	endtask

	task automatic t_wake();
		term_func_en <= '1;
		host_u.wake_line('1);
		repeat (4) @(posedge sys_clk);
		host_u.wake_line('0);
		for (n = 0; n < 10 && rst_oe !== 1'h1; n++) @(posedge sys_clk);
		chk({pend, rst_out}, 8'h03);
		@(posedge sys_clk);
		chk(dev_reset, 1'h1);
		for (n = 1; n < 100 && rst_oe === 1'h1; n++) @(posedge sys_clk);
		chk(8'(n), 8'(RST_PULSE_CYC));
		chk(irq_oe, 1'h1);
		wclr <= '1;
		host_u.wake_line('1);
		@(posedge sys_clk);
		wclr <= '0;
		term_func_en <= '0;
		repeat (4) @(posedge sys_clk);
		chk({pend, irq_oe}, 8'h00);
	endtask

	task automatic t_mux();
		chk(mux_mode, 1'h0);
		mux <= '1;
		d = 8'h3e;
		host_u.acc('0, '0, 6'h1c, d, got);
		chk(mem[6'h1c], 8'h3e);
		chk(mux_mode, 1'h1);
		d = 8'h00;
		host_u.acc('1, '0, 6'h1c, d, got);
		chk(d, 8'h3e);
	endtask

	initial begin
		for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h3c;
		repeat (16) @(posedge sys_clk);
		reset_n <= '1;
		repeat (3) @(posedge sys_clk);
		t_sep();
		t_ds();
		t_irq_pin();
		t_wake();
		t_mux();
		wrap_up();
	end
endmodule
